// *** hdl/svd_pkg.sv ***
// Package with register map, field layout, reset values and settle timing of the supply level detector
package svd_pkg;
  // Byte offsets on the register bus
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] FLAGS_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_EN_OFFSET = 4'h8;
  localparam logic [3:0] INT_CTRL_OFFSET = 4'hc;
  // Control register fields
  localparam int DIRECTION_BIT = 7;
  localparam int STABLE_BIT = 5;
  localparam int ENABLE_BIT = 4;
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 4;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
  localparam logic [3:0] LEVEL_RESERVED = 4'h0;
  // Flag, enable and global enable positions
  localparam int EVENT_FLAG_BIT = 2;
  localparam int EVENT_IRQ_EN_BIT = 2;
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  // Reset values
  localparam logic [3:0] LEVEL_RESET = 4'h5;
  localparam logic DIRECTION_RESET = 1'b0;
  localparam logic ENABLE_RESET = 1'b0;
  // Settle interval in timebase ticks; the timebase runs apart from sys_clk
  localparam logic [7:0] SETTLE_TICKS = 8'h14;
  // Settle state
  typedef enum logic [2:0] {
    SETTLE_OFF = 3'b001,
    SETTLE_WAIT = 3'b010,
    SETTLE_DONE = 3'b100
  } settle_state_e;
endpackage

// *** hdl/settle_if.sv ***
// Interface between the detector core and its reference settle timer
`timescale 1ns/10ps
interface settle_if;
  logic enable;
  logic tick;
  logic stable;
  modport core (output enable, output tick, input stable);
  modport timer (input enable, input tick, output stable);
endinterface

// *** hdl/settle_timer.sv ***
// Reference settle timer counting ticks of an independent timebase
`timescale 1ns/10ps
module settle_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Core link
  settle_if.timer st
);
  import svd_pkg::*;

  settle_state_e state_ff;
  logic [7:0] count_ff;

  // Counting ticks rather than sys_clk keeps the interval fixed at any core clock
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= SETTLE_OFF;
    end
    else
    begin
      unique case (state_ff)
        SETTLE_OFF:
        begin
          if (st.enable)
            state_ff <= SETTLE_WAIT;
        end
        SETTLE_WAIT:
        begin
          if (!st.enable)
            state_ff <= SETTLE_OFF;
          else if (st.tick && count_ff == SETTLE_TICKS - 8'h01)
            state_ff <= SETTLE_DONE;
        end
        SETTLE_DONE:
        begin
          if (!st.enable)
            state_ff <= SETTLE_OFF;
        end
        default:
        begin
          state_ff <= SETTLE_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      count_ff <= 8'h00;
    else if (state_ff != SETTLE_WAIT || !st.enable)
      count_ff <= 8'h00;
    else if (st.tick)
      count_ff <= count_ff + 8'h01;
  end

  assign st.stable = (state_ff == SETTLE_DONE);

  chk_stable_low_enable: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(st.enable) |=> !st.stable)
    else $error("stable flag high right after enable");

  chk_settle_tick_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(st.stable) |-> $past(count_ff) == SETTLE_TICKS - 8'h01 && $past(st.tick))
    else $error("stable flag rose before settle count expired");

  chk_restart_on_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    !st.enable |=> !st.stable && count_ff == 8'h00)
    else $error("settle interval not restarted after disable");
endmodule

// *** hdl/supply_level_detector.sv ***
// Supply level detector control, flag and interrupt logic with Avalon-MM register slave
`timescale 1ns/10ps
module supply_level_detector (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Analog front end
  input wire logic cmp_at_or_below,
  input wire logic cmp_at_or_above,
  input wire logic timebase_tick,
  output logic monitor_power,
  output logic [svd_pkg::LEVEL_W-1:0] divider_tap,
  output logic external_trip_route,
  // Core status
  input wire logic sleep_mode,
  output logic irq_request,
  output logic wake_request
);
  import svd_pkg::*;

  settle_if st ();

  logic trip_direction_ff;
  logic monitor_enable_ff;
  logic [LEVEL_W-1:0] trip_level_select_ff;
  logic supply_event_flag_ff;
  logic supply_event_irq_enable_ff;
  logic global_irq_enable_ff;
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic wake_ff;
  logic nxt_supply_event_flag;
  logic reference_stable;
  logic trip_hit;
  logic do_wr;
  logic lane0;
  logic [7:0] wbyte;
  logic [7:0] rd_mux;

  settle_timer u_settle (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .st(st.timer)
  );

  assign st.enable = monitor_enable_ff;
  assign st.tick = timebase_tick;
  assign reference_stable = st.stable;

  // Bus slave: one wait cycle per access, answer on the second edge
  assign waitrequest = (read | write) & ~ack_ff;
  assign do_wr = write & ack_ff;
  assign lane0 = byteenable[0];
  assign wbyte = writedata[7:0];

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= (read | write) & ~ack_ff;
  end

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (address)
      CTRL_OFFSET:
      begin
        rd_mux[DIRECTION_BIT] = trip_direction_ff;
        rd_mux[STABLE_BIT] = reference_stable;
        rd_mux[ENABLE_BIT] = monitor_enable_ff;
        rd_mux[LEVEL_LSB +: LEVEL_W] = trip_level_select_ff;
      end
      FLAGS_OFFSET:
      begin
        rd_mux[EVENT_FLAG_BIT] = supply_event_flag_ff;
      end
      IRQ_EN_OFFSET:
      begin
        rd_mux[EVENT_IRQ_EN_BIT] = supply_event_irq_enable_ff;
      end
      INT_CTRL_OFFSET:
      begin
        rd_mux[GLOBAL_IRQ_EN_BIT] = global_irq_enable_ff;
      end
      default:
      begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Unmapped addresses read zero and ignore writes
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      readdata_ff <= 32'h00000000;
    else if (read && !ack_ff)
      readdata_ff <= {24'h000000, rd_mux};
  end

  assign readdata = readdata_ff;

  // Control register; the stable bit is read-only and not stored here
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trip_direction_ff <= DIRECTION_RESET;
      monitor_enable_ff <= ENABLE_RESET;
      trip_level_select_ff <= LEVEL_RESET;
    end
    else if (do_wr && lane0 && address == CTRL_OFFSET)
    begin
      trip_direction_ff <= wbyte[DIRECTION_BIT];
      monitor_enable_ff <= wbyte[ENABLE_BIT];
      trip_level_select_ff <= wbyte[LEVEL_LSB +: LEVEL_W];
    end
  end

  // Interrupt enables
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      supply_event_irq_enable_ff <= 1'b0;
      global_irq_enable_ff <= 1'b0;
    end
    else if (do_wr && lane0)
    begin
      if (address == IRQ_EN_OFFSET)
        supply_event_irq_enable_ff <= wbyte[EVENT_IRQ_EN_BIT];
      if (address == INT_CTRL_OFFSET)
        global_irq_enable_ff <= wbyte[GLOBAL_IRQ_EN_BIT];
    end
  end

  // Analog controls; the comparator only counts while powered
  assign monitor_power = monitor_enable_ff;
  assign external_trip_route = (trip_level_select_ff == LEVEL_EXTERNAL);
  assign divider_tap = trip_level_select_ff;

  // Equal supply sets both comparator outputs, so it trips either way
  assign trip_hit = monitor_enable_ff & reference_stable
                  & (trip_direction_ff ? cmp_at_or_above : cmp_at_or_below);

  // Hardware set wins over a software clear in the same cycle
  always_comb
  begin
    nxt_supply_event_flag = supply_event_flag_ff;
    if (do_wr && lane0 && address == FLAGS_OFFSET)
      nxt_supply_event_flag = wbyte[EVENT_FLAG_BIT];
    if (trip_hit)
      nxt_supply_event_flag = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      supply_event_flag_ff <= 1'b0;
    else
      supply_event_flag_ff <= nxt_supply_event_flag;
  end

  // Sleep does not gate the monitor, so a crossing still wakes the core
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      wake_ff <= 1'b0;
    else
      wake_ff <= sleep_mode & trip_hit;
  end

  assign wake_request = wake_ff;
  assign irq_request = supply_event_flag_ff & supply_event_irq_enable_ff & global_irq_enable_ff;

  chk_enable_write_power: assert property (@(posedge sys_clk) disable iff (!resetn)
    do_wr && lane0 && address == CTRL_OFFSET |=> monitor_power == $past(writedata[ENABLE_BIT]))
    else $error("monitor power does not follow enable write");

  chk_flag_needs_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(supply_event_flag_ff) && !$past(do_wr) |-> $past(reference_stable) && $past(monitor_enable_ff))
    else $error("event flag set without stable reference");

  chk_falling_trip_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    monitor_enable_ff && reference_stable && !trip_direction_ff && cmp_at_or_below |=> supply_event_flag_ff)
    else $error("falling trip not flagged");

  chk_rising_trip_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    monitor_enable_ff && reference_stable && trip_direction_ff && cmp_at_or_above |=> supply_event_flag_ff)
    else $error("rising or equal trip not flagged");

  chk_level_write_taken: assert property (@(posedge sys_clk) disable iff (!resetn)
    do_wr && lane0 && address == CTRL_OFFSET |=> divider_tap == $past(writedata[3:0]))
    else $error("trip level write not taken");

  chk_external_route: assert property (@(posedge sys_clk) disable iff (!resetn)
    do_wr && lane0 && address == CTRL_OFFSET && writedata[3:0] == LEVEL_EXTERNAL |=> external_trip_route)
    else $error("external input not routed for code 1111");

  chk_irq_gating: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_request |-> supply_event_flag_ff && supply_event_irq_enable_ff && global_irq_enable_ff)
    else $error("interrupt requested without all enables");

  chk_sleep_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
    sleep_mode && trip_hit |=> wake_request && supply_event_flag_ff)
    else $error("crossing in sleep did not wake and flag");

  chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
    (read || write) && !ack_ff |-> waitrequest ##1 (!(read || write) || !waitrequest))
    else $error("bus access not answered on second edge");

  chk_ack_single: assert property (@(posedge sys_clk) disable iff (!resetn)
    ack_ff |=> !ack_ff)
    else $error("bus answer held for more than one cycle");

  chk_no_early_answer: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(read) || $rose(write) |-> waitrequest)
    else $error("new request answered without a wait cycle");

  // Register read-back as the bus master takes it
  chk_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    read && !waitrequest && address == CTRL_OFFSET
    |-> readdata[7:0] == {trip_direction_ff, 1'b0, $past(reference_stable), monitor_power, divider_tap})
    else $error("control register read back wrong");

  chk_flags_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    read && !waitrequest && address == FLAGS_OFFSET
    |-> readdata[7:0] == {5'h00, $past(supply_event_flag_ff), 2'h0})
    else $error("flag register read back wrong");

  chk_enables_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    read && !waitrequest && address == IRQ_EN_OFFSET
    |-> readdata[7:0] == {5'h00, supply_event_irq_enable_ff, 2'h0})
    else $error("interrupt enable read back wrong");

  chk_global_readback: assert property (@(posedge sys_clk) disable iff (!resetn)
    read && !waitrequest && address == INT_CTRL_OFFSET |-> readdata[7:0] == {global_irq_enable_ff, 7'h00})
    else $error("global enable read back wrong");

  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h00000000)
    else $error("unmapped address read not zero");

  chk_read_high_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // Event flag set, hold and clear, then interrupt enable, external route, stable, control and wake checks
  chk_no_flag_unstable: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reference_stable && !supply_event_flag_ff && !(do_wr && address == FLAGS_OFFSET)
    |=> !supply_event_flag_ff)
    else $error("event flag set before reference stable");

  chk_disabled_no_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    !monitor_enable_ff && !supply_event_flag_ff && !(do_wr && address == FLAGS_OFFSET)
    |=> !supply_event_flag_ff)
    else $error("event flag set while detector off");

  chk_flag_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    supply_event_flag_ff && !(do_wr && lane0 && address == FLAGS_OFFSET) |=> supply_event_flag_ff)
    else $error("event flag lost without software clear");

  chk_flag_clear_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    do_wr && lane0 && address == FLAGS_OFFSET && !writedata[EVENT_FLAG_BIT] && !trip_hit
    |=> !supply_event_flag_ff)
    else $error("software clear of event flag not taken");

  chk_set_beats_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    do_wr && lane0 && address == FLAGS_OFFSET && trip_hit |=> supply_event_flag_ff)
    else $error("clear won over a trip in the same cycle");

  chk_irq_needs_enables: assert property (@(posedge sys_clk) disable iff (!resetn)
    !global_irq_enable_ff || !supply_event_irq_enable_ff |-> !irq_request)
    else $error("interrupt requested with an enable clear");

  chk_external_decode: assert property (@(posedge sys_clk) disable iff (!resetn)
    external_trip_route == (divider_tap == LEVEL_EXTERNAL))
    else $error("external route does not match level code");

  chk_disable_drops_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
    !monitor_enable_ff |=> !reference_stable)
    else $error("stable flag kept while detector off");

  chk_ctrl_needs_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(do_wr && lane0 && address == CTRL_OFFSET) |=> $stable(divider_tap) && $stable(monitor_power))
    else $error("control outputs changed without a write");

  chk_wake_needs_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
    wake_request |-> $past(sleep_mode) && $past(trip_hit))
    else $error("wake requested without sleep crossing");

  chk_no_wake_awake: assert property (@(posedge sys_clk) disable iff (!resetn)
    !sleep_mode |=> !wake_request)
    else $error("wake requested while awake");
endmodule

// *** verification/supply_level_detector_tb.sv ***
// Self-checking testbench for the supply level detector register and event logic
`timescale 1ns/10ps
module supply_level_detector_tb;
  import svd_pkg::*;
  logic sys_clk, resetn, read, write, cmp_at_or_below, cmp_at_or_above, timebase_tick, sleep_mode;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata;
  logic waitrequest, monitor_power, external_trip_route, irq_request, wake_request;
  logic [3:0] divider_tap;
  logic [31:0] exp_q[$];
  int err_count, comparisons, seed;
  supply_level_detector u_dut (.sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cmp_at_or_below(cmp_at_or_below), .cmp_at_or_above(cmp_at_or_above),
    .timebase_tick(timebase_tick), .monitor_power(monitor_power), .divider_tap(divider_tap),
    .external_trip_route(external_trip_route), .sleep_mode(sleep_mode), .irq_request(irq_request),
    .wake_request(wake_request));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic results();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; a bounded wait of 100 cycles ends a hang
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    int n;
    r = $random(seed);
    n = 0;
    @(posedge sys_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {r[31:8], d};
    byteenable <= 4'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      err_count++;
      results();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge sys_clk) timebase_tick <= 1'b1;
      @(posedge sys_clk) timebase_tick <= 1'b0;
    end
  endtask
  task automatic pins(input logic [3:0] v);
    @(negedge sys_clk);
    chk(32'({monitor_power, external_trip_route, irq_request, wake_request}), 32'(v));
  endtask
  // Read data are compared at the one edge where the answer is taken
  always @(posedge sys_clk)
    if (read === 1'b1 && waitrequest === 1'b0)
      chk(readdata, exp_q.pop_front());
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results();
  end
  initial
  begin
    logic [31:0] r;
    seed = 11061;
    {resetn, read, write, cmp_at_or_below, cmp_at_or_above, timebase_tick, sleep_mode} = '0;
    address = 4'h0;
    byteenable = 4'h0;
    writedata = 32'h0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    pins(4'h0);
    chk(32'(divider_tap), 32'(LEVEL_RESET));
    rd(CTRL_OFFSET, {DIRECTION_RESET, 2'b00, ENABLE_RESET, LEVEL_RESET});
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      r = $random(seed);
      wr(CTRL_OFFSET, {r[0], r[2:1], 1'b0, 4'(i)});
      rd(CTRL_OFFSET, {r[0], 3'b000, 4'(i)});
      pins({1'b0, 4'(i) == LEVEL_EXTERNAL, 2'b00});
      chk(32'(divider_tap), 32'(i));
    end
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h00);
    $display("test level codes done");
    wr(CTRL_OFFSET, 8'h1f);
    wr(FLAGS_OFFSET, 8'h00);
    pins(4'hc);
    @(posedge sys_clk);
    cmp_at_or_below <= 1'b1;
    ticks(32'(SETTLE_TICKS) - 1);
    rd(CTRL_OFFSET, 8'h1f);
    rd(FLAGS_OFFSET, 8'h00);
    cmp_at_or_below <= 1'b0;
    ticks(1);
    rd(CTRL_OFFSET, 8'h3f);
    $display("test settle done");
    wr(IRQ_EN_OFFSET, 8'h04);
    wr(INT_CTRL_OFFSET, 8'h80);
    pins(4'hc);
    @(posedge sys_clk);
    cmp_at_or_below <= 1'b1;
    sleep_mode <= 1'b1;
    @(posedge sys_clk);
    pins(4'hf);
    @(posedge sys_clk);
    cmp_at_or_below <= 1'b0;
    sleep_mode <= 1'b0;
    rd(FLAGS_OFFSET, 8'h04);
    wr(FLAGS_OFFSET, 8'h00);
    pins(4'hc);
    wr(INT_CTRL_OFFSET, 8'h00);
    wr(FLAGS_OFFSET, 8'h04);
    pins(4'hc);
    wr(INT_CTRL_OFFSET, 8'h80);
    pins(4'he);
    wr(FLAGS_OFFSET, 8'h00);
    $display("test event and irq done");
    wr(CTRL_OFFSET, 8'h9f);
    cmp_at_or_below <= 1'b1;
    rd(FLAGS_OFFSET, 8'h00);
    cmp_at_or_above <= 1'b1;
    rd(FLAGS_OFFSET, 8'h04);
    {cmp_at_or_below, cmp_at_or_above} <= 2'b00;
    wr(FLAGS_OFFSET, 8'h00);
    $display("test direction done");
    wr(CTRL_OFFSET, 8'h0f);
    wr(CTRL_OFFSET, 8'h03);
    wr(CTRL_OFFSET, 8'h83);
    cmp_at_or_above <= 1'b1;
    wr(CTRL_OFFSET, 8'h93);
    wr(FLAGS_OFFSET, 8'h00);
    wr(IRQ_EN_OFFSET, 8'h04);
    wr(INT_CTRL_OFFSET, 8'h80);
    rd(CTRL_OFFSET, 8'h93);
    rd(IRQ_EN_OFFSET, 8'h04);
    rd(INT_CTRL_OFFSET, 8'h80);
    rd(FLAGS_OFFSET, 8'h00);
    pins(4'h8);
    ticks(32'(SETTLE_TICKS));
    rd(FLAGS_OFFSET, 8'h04);
    wr(FLAGS_OFFSET, 8'h00);
    rd(FLAGS_OFFSET, 8'h04);
    pins(4'ha);
    @(posedge sys_clk);
    cmp_at_or_above <= 1'b0;
    wr(FLAGS_OFFSET, 8'h00);
    rd(FLAGS_OFFSET, 8'h00);
    $display("test setup order done");
    wr(CTRL_OFFSET, 8'h0f);
    pins(4'h4);
    rd(CTRL_OFFSET, 8'h0f);
    wr(CTRL_OFFSET, 8'h1f);
    ticks(32'(SETTLE_TICKS) - 1);
    rd(CTRL_OFFSET, 8'h1f);
    ticks(1);
    rd(CTRL_OFFSET, 8'h3f);
    $display("test re-enable done");
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    pins(4'h0);
    rd(CTRL_OFFSET, {DIRECTION_RESET, 2'b00, ENABLE_RESET, LEVEL_RESET});
    rd(FLAGS_OFFSET, 8'h00);
    $display("test mid-run reset done");
    results();
  end
endmodule
